/* core/bpl_pin_lanes.sv */
// Operation
// - Eight-bit region: line 0 is write strobe, line 1 high, lines 2:3 carry A30:31.
// - Sixteen-bit region: line 0 upper-byte, line 1 lower-byte, lines 2:3 carry A30:31.
// - Thirty-two-bit region: lines 0:3 enable bytes 0:3, active low, per size.
// - Row cycle: a6..a13 on A11..A18, a12..a22 on A19..A29.
// - Column cycle: a6..a12 on A12..A18, a21..a31 on A19..A29, A11 undefined.
// - In reset: chip selects, shared strobes, data float; DMA acknowledges high.
// - In reset: external acknowledge and DRAM output and write enables high.
// - In reset: error and hold grant low; output-enable pin floats.
// - Reset pin floats always, except while the device initiates a system reset.
// - In reset: read/write floats, transfer controls become inputs, test output floats.
// - During hold grant the address pins float and become inputs.
// - During hold grant the data bus floats; the external master drives it.
// - During hold: output-enable pin gives size bit 1, control 3 size bit 0.
// - During hold the lane pins are inputs for A4:5 and A30:31.
// - During hold shared pins float as chip selects, stay working as row strobes.
// - During hold, strobes, enables, error, acknowledge, request, status keep switching.
// - Byte or halfword banks put A30:31 on lines 2:3 in every mux mode.
`timescale 1ns/10ps
`include "bpl_regs.svh"

module bpl_pin_lanes (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire bpl_pkg::bpl_acc_type acc,
    input wire bpl_pkg::bpl_ctl_type ctl,
    input wire logic bus_idle,
    input wire logic hold_request_pin,
    input wire logic reset_pin_in,
    input wire logic read_enable_in,
    input wire logic [0:3] transfer_cycle_controls_in,
    input wire logic [6:29] addr_in,
    input wire logic [0:3] write_lane_enables_in,
    output bpl_pkg::bpl_pins_type pins,
    output logic reset_pin_out,
    output bpl_pkg::bpl_ext_type ext_master,
    output logic reset_pin_level
);

    bpl_pkg::bpl_state_type s_q;
    bpl_pkg::bpl_state_type s_d;
    bpl_pkg::bpl_ext_type ext_raw;
    logic [0:3] lanes_calc;
    logic [6:29] addr_calc;
    logic grant_d;

    // Lane encoding per region width and transfer size; DRAM narrower than 32 bits keeps lines 0:1 high.
    function automatic logic [0:3] lane_code(input bpl_pkg::bpl_acc_type a);
        logic [0:1] lo;
        logic [0:3] r;
        lo = a.addr[30:31];
        r = `BPL_LANES_IDLE;
        case (a.width)
            bpl_pkg::BPL_W8: begin
                r = {!a.write_strobe, 1'b1, lo};
            end
            bpl_pkg::BPL_W16: begin
                if (a.size == bpl_pkg::BPL_BYTE) begin
                    r = {lo[1], !lo[1], lo};
                end else begin
                    r = {2'b00, lo};
                end
            end
            bpl_pkg::BPL_W32: begin
                case (a.size)
                    bpl_pkg::BPL_WORD: r = 4'h0;
                    bpl_pkg::BPL_HALF: r = lo[0] ? 4'hc : 4'h3;
                    default: r = ~(4'h8 >> lo);
                endcase
            end
            default: r = `BPL_LANES_IDLE;
        endcase
        if (a.dram && a.width != bpl_pkg::BPL_W32) begin
            r[0:1] = 2'b11;
        end
        return r;
    endfunction : lane_code

    // Address pins; A6:10 always keep their plain value.
    always_comb begin
        addr_calc = acc.addr[6:29];
        case (acc.mux)
            bpl_pkg::BPL_MUX_ROW: begin
                for (int i = 0; i < `BPL_LOW_FIELD_LEN; i++) begin
                    addr_calc[`BPL_ROW_LOW_BASE + i] = acc.addr[`BPL_ROW_LOW_SRC + i];
                end
                for (int i = 0; i < `BPL_HIGH_FIELD_LEN; i++) begin
                    addr_calc[`BPL_ROW_HIGH_BASE + i] = acc.addr[`BPL_ROW_HIGH_SRC + i];
                end
            end
            bpl_pkg::BPL_MUX_COL: begin
                // A11 is undefined here; it keeps its plain value to save a mux input.
                for (int i = 0; i < `BPL_LOW_FIELD_LEN - 1; i++) begin
                    addr_calc[`BPL_COL_LOW_BASE + i] = acc.addr[`BPL_COL_LOW_SRC + i];
                end
                for (int i = 0; i < `BPL_HIGH_FIELD_LEN; i++) begin
                    addr_calc[`BPL_ROW_HIGH_BASE + i] = acc.addr[`BPL_COL_HIGH_SRC + i];
                end
            end
            default: addr_calc = acc.addr[6:29];
        endcase
    end

    assign lanes_calc = lane_code(acc);
    assign ext_raw = '{addr: addr_in, lanes: write_lane_enables_in,
                       ext_size_bit1: read_enable_in,
                       ext_size_bit0: transfer_cycle_controls_in[3]};

    // Grant is given only on an idle bus and is then held for as long as the request stays.
    assign grant_d = s_q.hreq_s2 && (s_q.pins.hold_grant || bus_idle);

    // Next state of every pin, plus the input synchronisers.
    always_comb begin
        s_d = s_q;
        s_d.hreq_s1 = hold_request_pin;
        s_d.hreq_s2 = s_q.hreq_s1;
        s_d.rst_s1 = reset_pin_in;
        s_d.rst_s2 = s_q.rst_s1;
        s_d.ext_s1 = ext_raw;
        s_d.ext_s2 = s_q.ext_s1;
        // Lines that keep working in both modes.
        s_d.pins.column_mux_strobe = ctl.column_mux_strobe;
        s_d.pins.bus_request_out = ctl.bus_request_out;
        s_d.pins.column_strobes = ctl.column_strobes;
        s_d.pins.external_acknowledge = ctl.external_acknowledge;
        s_d.pins.dram_output_enable = ctl.dram_output_enable;
        s_d.pins.dram_write_enable = ctl.dram_write_enable;
        s_d.pins.error_out = ctl.error_out;
        s_d.pins.trace_status_outputs = ctl.trace_status_outputs;
        s_d.pins.serial_transmit_out = ctl.serial_transmit_out;
        s_d.pins.tdo = ctl.tdo;
        s_d.pins.tdo_oe = 1'b1;
        s_d.pins.reset_oe = ctl.initiate_reset;
        s_d.pins.shared_select_row_strobes = ctl.shared_select_row_strobes;
        s_d.pins.hold_grant = grant_d;
        s_d.pins.addr = addr_calc;
        s_d.pins.write_lane_enables = lanes_calc;
        s_d.pins.data = acc.data;
        s_d.pins.rw = !(acc.valid && acc.write);
        s_d.pins.read_enable = ctl.read_enable;
        if (grant_d) begin
            s_d.pins.addr_oe = 1'b0;
            s_d.pins.data_oe = 1'b0;
            s_d.pins.read_enable_oe = 1'b0;
            s_d.pins.tc_oe = `BPL_TC_HOLD_OE;
            s_d.pins.transfer_cycle_controls = `BPL_TC_IDLE;
            s_d.pins.lanes_oe = 1'b0;
            s_d.pins.shared_oe = ctl.row_strobe_mode;
            s_d.pins.dma_acknowledge_lines = `BPL_DMA_ACK_IDLE;
            s_d.pins.lower_cs_oe = 1'b0;
            s_d.pins.rw_oe = 1'b0;
        end else begin
            s_d.pins.addr_oe = 1'b1;
            s_d.pins.data_oe = acc.valid && acc.write;
            s_d.pins.read_enable_oe = 1'b1;
            s_d.pins.tc_oe = `BPL_TC_IDLE;
            s_d.pins.transfer_cycle_controls = ctl.transfer_cycle_controls;
            s_d.pins.lanes_oe = 1'b1;
            s_d.pins.shared_oe = 1'b1;
            s_d.pins.dma_acknowledge_lines = ctl.dma_acknowledge_lines;
            s_d.pins.lower_cs_oe = 1'b1;
            s_d.pins.lower_chip_selects = ctl.lower_chip_selects;
            s_d.pins.rw_oe = 1'b1;
        end
    end

    // Reset puts every pin in its reset state straight away, without waiting for a clock.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            // Every enable clears, so pins float and grant and error sit low.
            s_q <= '0;
            s_q.pins.column_strobes <= `BPL_COL_STROBE_IDLE;
            s_q.pins.dma_acknowledge_lines <= `BPL_DMA_ACK_IDLE;
            s_q.pins.external_acknowledge <= 1'b1;
            s_q.pins.dram_output_enable <= 1'b1;
            s_q.pins.dram_write_enable <= 1'b1;
            s_q.pins.transfer_cycle_controls <= `BPL_TC_IDLE;
            s_q.pins.trace_status_outputs <= `BPL_TRACE_IDLE;
            s_q.pins.write_lane_enables <= `BPL_LANES_IDLE;
            s_q.pins.serial_transmit_out <= 1'b1;
            s_q.pins.rw <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign pins = s_q.pins;
    assign reset_pin_out = 1'b0; // Only ever pulls low.
    assign ext_master = s_q.ext_s2;
    assign reset_pin_level = s_q.rst_s2;

    // First sampled edge after release still shows the reset pin states.
    chk_reset_float: assert property (@(posedge clk_sys) $rose(rst_b) |->
        !pins.addr_oe && !pins.column_mux_strobe && !pins.bus_request_out
        && pins.column_strobes == `BPL_COL_STROBE_IDLE)
        else $error("Address or strobes wrong at reset release.");
    chk_reset_selects: assert property (@(posedge clk_sys) $rose(rst_b) |->
        !pins.lower_cs_oe && !pins.shared_oe && !pins.data_oe
        && pins.dma_acknowledge_lines == `BPL_DMA_ACK_IDLE)
        else $error("Selects, data or DMA acks wrong in reset.");
    chk_reset_dram: assert property (@(posedge clk_sys) $rose(rst_b) |->
        pins.external_acknowledge && pins.dram_output_enable && pins.dram_write_enable)
        else $error("Acknowledge or DRAM enables not high in reset.");
    chk_reset_misc: assert property (@(posedge clk_sys) $rose(rst_b) |->
        !pins.error_out && !pins.hold_grant && !pins.read_enable_oe && !pins.rw_oe
        && pins.tc_oe == 4'h0 && !pins.tdo_oe && !pins.lanes_oe && pins.serial_transmit_out)
        else $error("Misc pins wrong in reset.");
    // Out of reset, the reset pin drive follows the controller's request of the cycle before.
    chk_reset_pin_drive: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $past(rst_b) |-> pins.reset_oe == $past(ctl.initiate_reset))
        else $error("Reset pin driven without a system reset request.");
    chk_hold_float: assert property (@(posedge clk_sys) disable iff (!rst_b)
        pins.hold_grant |-> !pins.addr_oe && !pins.data_oe && !pins.lanes_oe
        && !pins.read_enable_oe && pins.tc_oe == `BPL_TC_HOLD_OE)
        else $error("Pin driven while hold is granted.");
    chk_hold_selects: assert property (@(posedge clk_sys) disable iff (!rst_b)
        pins.hold_grant |-> pins.shared_oe == $past(ctl.row_strobe_mode)
        && !pins.lower_cs_oe && !pins.rw_oe && pins.dma_acknowledge_lines == 4'hf)
        else $error("Shared pins or selects wrong during hold.");
    chk_hold_grant: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(hold_request_pin) && bus_idle ##1 bus_idle ##1 bus_idle |=> pins.hold_grant)
        else $error("Hold grant not given three edges after request.");
    chk_lane_map: assert property (@(posedge clk_sys) disable iff (!rst_b)
        acc.width == bpl_pkg::BPL_W32 && acc.size == bpl_pkg::BPL_WORD |=>
        pins.write_lane_enables == 4'h0)
        else $error("Lane enables do not follow the access.");
    chk_lane_narrow: assert property (@(posedge clk_sys) disable iff (!rst_b)
        acc.width != bpl_pkg::BPL_W32 |=> pins.write_lane_enables[2:3] == $past(acc.addr[30:31]))
        else $error("Narrow bank lanes 2:3 lost A30:31.");
    chk_row_mux: assert property (@(posedge clk_sys) disable iff (!rst_b)
        acc.mux == bpl_pkg::BPL_MUX_ROW |=>
        pins.addr[11:18] == $past(acc.addr[6:13]) && pins.addr[19:29] == $past(acc.addr[12:22]))
        else $error("Row cycle address wrong.");
    chk_col_mux: assert property (@(posedge clk_sys) disable iff (!rst_b)
        acc.mux == bpl_pkg::BPL_MUX_COL |=>
        pins.addr[12:18] == $past(acc.addr[6:12]) && pins.addr[19:29] == $past(acc.addr[21:31]))
        else $error("Column cycle address wrong.");

    cov_hold: cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(pins.hold_grant));
    cov_col: cover property (@(posedge clk_sys) disable iff (!rst_b)
        acc.mux == bpl_pkg::BPL_MUX_ROW ##1 acc.mux == bpl_pkg::BPL_MUX_COL);
    cov_w16_odd: cover property (@(posedge clk_sys) disable iff (!rst_b)
        acc.width == bpl_pkg::BPL_W16 && acc.size == bpl_pkg::BPL_BYTE && acc.addr[31]);

endmodule : bpl_pin_lanes

/* core/bpl_regs.svh */
`ifndef BPL_REGS_SVH
`define BPL_REGS_SVH

// Pin ranges of the multiplexed address field.
`define BPL_ROW_LOW_BASE 11
`define BPL_ROW_HIGH_BASE 19
`define BPL_ROW_LOW_SRC 6
`define BPL_ROW_HIGH_SRC 12
`define BPL_COL_LOW_BASE 12
`define BPL_COL_LOW_SRC 6
`define BPL_COL_HIGH_SRC 21
`define BPL_LOW_FIELD_LEN 8
`define BPL_HIGH_FIELD_LEN 11

// Levels that the pins show while reset is active, plus the transfer-control enables during hold.
`define BPL_LANES_IDLE 4'hf
`define BPL_DMA_ACK_IDLE 4'hf
`define BPL_COL_STROBE_IDLE 4'hf
`define BPL_TC_IDLE 4'hf
`define BPL_TC_HOLD_OE 4'he
`define BPL_TRACE_IDLE 7'h00

`endif

/* core/bpl_pkg.sv */
package bpl_pkg;

    // Port width of the addressed region.
    typedef enum logic [1:0] {
        BPL_W8,
        BPL_W16,
        BPL_W32
    } bpl_width_type;

    // Size of one transfer.
    typedef enum logic [1:0] {
        BPL_BYTE,
        BPL_HALF,
        BPL_WORD
    } bpl_size_type;

    // Address cycle of the current access.
    typedef enum logic [1:0] {
        BPL_MUX_OFF,
        BPL_MUX_ROW,
        BPL_MUX_COL
    } bpl_mux_type;

    // One access as the bus interface unit presents it.
    typedef struct packed {
        logic valid;
        logic write;
        logic write_strobe;
        logic dram;
        bpl_width_type width;
        bpl_size_type size;
        bpl_mux_type mux;
        logic [0:31] addr;
        logic [0:31] data;
    } bpl_acc_type;

    // Control levels that the rest of the controller produces.
    typedef struct packed {
        logic column_mux_strobe;
        logic bus_request_out;
        logic [0:3] column_strobes;
        logic [0:3] lower_chip_selects;
        logic [0:3] shared_select_row_strobes;
        logic row_strobe_mode;
        logic [0:3] dma_acknowledge_lines;
        logic external_acknowledge;
        logic dram_output_enable;
        logic dram_write_enable;
        logic error_out;
        logic read_enable;
        logic [0:3] transfer_cycle_controls;
        logic tdo;
        logic [0:6] trace_status_outputs;
        logic serial_transmit_out;
        logic initiate_reset;
    } bpl_ctl_type;

    // Values that an external master supplies while it holds the bus.
    typedef struct packed {
        logic [6:29] addr;
        logic [0:3] lanes;
        logic ext_size_bit1;
        logic ext_size_bit0;
    } bpl_ext_type;

    // Every pin value and enable the block drives.
    typedef struct packed {
        logic [6:29] addr;
        logic addr_oe;
        logic column_mux_strobe;
        logic bus_request_out;
        logic [0:3] column_strobes;
        logic [0:3] lower_chip_selects;
        logic lower_cs_oe;
        logic [0:3] shared_select_row_strobes;
        logic shared_oe;
        logic [0:31] data;
        logic data_oe;
        logic [0:3] dma_acknowledge_lines;
        logic external_acknowledge;
        logic dram_output_enable;
        logic dram_write_enable;
        logic error_out;
        logic hold_grant;
        logic read_enable;
        logic read_enable_oe;
        logic reset_oe;
        logic rw;
        logic rw_oe;
        logic [0:3] transfer_cycle_controls;
        logic [0:3] tc_oe;
        logic tdo;
        logic tdo_oe;
        logic [0:6] trace_status_outputs;
        logic [0:3] write_lane_enables;
        logic lanes_oe;
        logic serial_transmit_out;
    } bpl_pins_type;

    // All state of the pin block.
    typedef struct packed {
        bpl_pins_type pins;
        logic hreq_s1;
        logic hreq_s2;
        logic rst_s1;
        logic rst_s2;
        bpl_ext_type ext_s1;
        bpl_ext_type ext_s2;
    } bpl_state_type;

endpackage : bpl_pkg

/* test/bpl_far_side.sv */
`timescale 1ns/10ps

// External master and pin wiring: it drives the shared pins only while it holds the grant.
module bpl_far_side (
    input wire logic clk_sys,
    input wire logic want_bus,
    input wire bpl_pkg::bpl_ext_type ext_val,
    input wire bpl_pkg::bpl_pins_type pins,
    output logic hold_request_pin,
    output logic reset_pin_in,
    output logic read_enable_in,
    output logic [0:3] transfer_cycle_controls_in,
    output logic [6:29] addr_in,
    output logic [0:3] write_lane_enables_in
);
    logic [0:32] last_q = '0;
    logic drv;

    // Lines that nobody drives show the inverse of their last level, so a stale value
    // can never pass for a fresh one. The data bus has no input port in this block,
    // so the master's own drive of it is not modelled.
    always_comb begin
        drv = pins.hold_grant;
        hold_request_pin = want_bus;
        reset_pin_in = pins.reset_oe ? 1'b0 : 1'b1; // Pull-up on the open-drain pin.
        addr_in = pins.addr_oe ? pins.addr : (drv ? ext_val.addr : ~last_q[0:23]);
        write_lane_enables_in = pins.lanes_oe ? pins.write_lane_enables :
            (drv ? ext_val.lanes : ~last_q[24:27]);
        read_enable_in = pins.read_enable_oe ? pins.read_enable :
            (drv ? ext_val.ext_size_bit1 : ~last_q[28]);
        for (int i = 0; i < 4; i++) begin
            transfer_cycle_controls_in[i] = pins.tc_oe[i] ? pins.transfer_cycle_controls[i] :
                ((drv && i == 3) ? ext_val.ext_size_bit0 : ~last_q[29+i]);
        end
    end

    // Remember the wire levels for the released-line pattern.
    always_ff @(posedge clk_sys) begin
        last_q <= {addr_in, write_lane_enables_in, read_enable_in, transfer_cycle_controls_in};
    end
endmodule : bpl_far_side

/* test/bpl_pin_lanes_tb.sv */
`timescale 1ns/10ps

module bpl_pin_lanes_tb;
    logic clk_sys = 1'b0, rst_b = 1'b0, bus_idle = 1'b1, want_bus = 1'b0;
    logic reset_pin_out, reset_pin_level, hold_request_pin, reset_pin_in, read_enable_in;
    logic [0:3] tc_in, lanes_in;
    logic [6:29] addr_in;
    bpl_pkg::bpl_acc_type acc = '0;
    bpl_pkg::bpl_ctl_type ctl = '0;
    bpl_pkg::bpl_ext_type ext_val = {24'ha5c3e1, 4'h9, 1'b1, 1'b0};
    bpl_pkg::bpl_pins_type pins;
    bpl_pkg::bpl_ext_type ext_master;
    int failures = 0, check_count = 0;

    bpl_pin_lanes i_bpl_pin_lanes (.clk_sys(clk_sys), .rst_b(rst_b), .acc(acc), .ctl(ctl),
        .bus_idle(bus_idle), .hold_request_pin(hold_request_pin), .reset_pin_in(reset_pin_in),
        .read_enable_in(read_enable_in), .transfer_cycle_controls_in(tc_in), .addr_in(addr_in),
        .write_lane_enables_in(lanes_in), .pins(pins), .reset_pin_out(reset_pin_out),
        .ext_master(ext_master), .reset_pin_level(reset_pin_level));

    bpl_far_side i_bpl_far_side (.clk_sys(clk_sys), .want_bus(want_bus), .ext_val(ext_val),
        .pins(pins), .hold_request_pin(hold_request_pin), .reset_pin_in(reset_pin_in),
        .read_enable_in(read_enable_in), .transfer_cycle_controls_in(tc_in),
        .addr_in(addr_in), .write_lane_enables_in(lanes_in));

    // Free-running 25 MHz system clock.
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic cmp_vec(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : cmp_vec

    task automatic print_verdict();
        if (failures == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    // Every pin level while reset is low, whatever the controller asks for.
    task automatic check_reset();
        cmp_vec(32'({pins.addr_oe, pins.column_mux_strobe, pins.bus_request_out,
            pins.column_strobes}), 32'h0f);
        cmp_vec(32'({pins.lower_cs_oe, pins.shared_oe, pins.data_oe,
            pins.dma_acknowledge_lines}), 32'h0f);
        cmp_vec(32'({pins.external_acknowledge, pins.dram_output_enable,
            pins.dram_write_enable}), 32'h7);
        cmp_vec(32'({pins.error_out, pins.hold_grant, pins.read_enable_oe}), 32'h0);
        cmp_vec(32'(pins.reset_oe), 32'h0);
        cmp_vec(32'({pins.rw_oe, pins.tc_oe, pins.tdo_oe}), 32'h0);
        cmp_vec(32'({pins.trace_status_outputs, pins.lanes_oe,
            pins.serial_transmit_out}), 32'h1);
    endtask : check_reset

    // Every legal width, size and byte offset; the expected lanes are built from the rules.
    task automatic run_lanes();
        bpl_pkg::bpl_width_type w;
        bpl_pkg::bpl_size_type s;
        logic [1:0] av;
        logic [0:3] e;
        logic ok;
        for (int k = 0; k < 36; k++) begin
            w = bpl_pkg::bpl_width_type'(k / 12);
            s = bpl_pkg::bpl_size_type'((k / 4) % 3);
            av = k[1:0];
            ok = (w == bpl_pkg::BPL_W8) ? (s == bpl_pkg::BPL_BYTE) :
                (w == bpl_pkg::BPL_W16) ? (s != bpl_pkg::BPL_WORD && !(s == bpl_pkg::BPL_HALF && av[0])) :
                !((s == bpl_pkg::BPL_WORD && av != 2'h0) || (s == bpl_pkg::BPL_HALF && av[0]));
            if (ok) begin
                @(posedge clk_sys);
                acc.valid <= 1'b1;
                acc.write <= 1'b1;
                acc.write_strobe <= (w == bpl_pkg::BPL_W8) ? av[0] : 1'b1;
                acc.width <= w;
                acc.size <= s;
                acc.mux <= bpl_pkg::BPL_MUX_OFF;
                acc.addr <= {30'h2aaaaaa5, av};
                if (w == bpl_pkg::BPL_W8) begin
                    e = {~av[0], 1'b1, av};
                end else if (w == bpl_pkg::BPL_W16) begin
                    e = (s == bpl_pkg::BPL_HALF) ? {2'b00, av} : {av[0], ~av[0], av};
                end else if (s == bpl_pkg::BPL_BYTE) begin
                    e = ~(4'b1000 >> av);
                end else begin
                    e = (s == bpl_pkg::BPL_WORD) ? 4'h0 : ((av == 2'h0) ? 4'h3 : 4'hc);
                end
                @(posedge clk_sys);
                #1;
                cmp_vec(32'(pins.write_lane_enables), 32'(e));
            end
        end
    endtask : run_lanes

    // Row then column cycle of one address, narrow bank so the lanes carry A30:31 too.
    task automatic run_mux();
        logic [0:31] a;
        logic [6:29] e;
        a = 32'h9c3b5e71;
        for (int m = 1; m < 3; m++) begin
            @(posedge clk_sys);
            acc.addr <= a;
            acc.mux <= bpl_pkg::bpl_mux_type'(m);
            acc.width <= bpl_pkg::BPL_W16;
            acc.size <= bpl_pkg::BPL_BYTE;
            acc.dram <= 1'b1;
            for (int p = 11; p < 30; p++) begin
                e[p] = (m == 1) ? a[(p < 19) ? p - 5 : p - 7] : a[(p < 19) ? p - 6 : p + 2];
            end
            @(posedge clk_sys);
            #1;
            cmp_vec(32'(pins.addr[12:29]), 32'(e[12:29]));
            cmp_vec(32'({pins.addr_oe, pins.write_lane_enables}), 32'h1d);
            if (m == 1) begin
                cmp_vec(32'(pins.addr[11]), 32'(e[11]));
            end
        end
    endtask : run_mux

    // A request on a busy bus gets no grant; the request is then dropped again.
    task automatic run_hold_busy();
        @(posedge clk_sys);
        want_bus <= 1'b1;
        bus_idle <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        cmp_vec(32'({pins.hold_grant, pins.addr_oe}), 32'h1);
        want_bus <= 1'b0;
        bus_idle <= 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask : run_hold_busy

    // The master takes the bus, the controller keeps switching, then the bus comes back.
    task automatic run_hold();
        @(posedge clk_sys);
        want_bus <= 1'b1;
        ctl.row_strobe_mode <= 1'b1;
        ctl.column_strobes <= 4'h5;
        ctl.shared_select_row_strobes <= 4'ha;
        repeat (2) @(posedge clk_sys);
        #1;
        cmp_vec(32'(pins.hold_grant), 32'h0);
        @(posedge clk_sys);
        #1;
        cmp_vec(32'({pins.hold_grant, pins.addr_oe, pins.data_oe}), 32'h4);
        cmp_vec(32'({pins.lanes_oe, pins.read_enable_oe, pins.tc_oe}), 32'h0e);
        cmp_vec(32'({pins.transfer_cycle_controls[0:2], pins.dma_acknowledge_lines,
            pins.lower_cs_oe, pins.rw_oe}), 32'h1fc);
        cmp_vec(32'({pins.shared_oe, pins.shared_select_row_strobes,
            pins.column_strobes}), 32'h1a5);
        ctl.row_strobe_mode <= 1'b0;
        ctl.column_strobes <= 4'hc;
        ctl.error_out <= 1'b1;
        @(posedge clk_sys);
        #1;
        cmp_vec(32'({pins.shared_oe, pins.column_strobes, pins.error_out}), 32'h19);
        @(posedge clk_sys);
        #1;
        cmp_vec(32'(ext_master), 32'(ext_val));
        want_bus <= 1'b0;
        ctl.error_out <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        cmp_vec(32'({pins.hold_grant, pins.addr_oe}), 32'h1);
    endtask : run_hold

    // The device pulls its own reset pin only while it asks for a system reset.
    task automatic run_reset_pin();
        @(posedge clk_sys);
        ctl.initiate_reset <= 1'b1;
        @(posedge clk_sys);
        #1;
        cmp_vec(32'(pins.reset_oe), 32'h1);
        repeat (2) @(posedge clk_sys);
        #1;
        cmp_vec(32'(reset_pin_level), 32'h0);
        ctl.initiate_reset <= 1'b0;
        @(posedge clk_sys);
        #1;
        cmp_vec(32'(pins.reset_oe), 32'h0);
    endtask : run_reset_pin

    // A second reset in mid-run with every controller level turned round.
    task automatic run_mid_reset();
        @(posedge clk_sys);
        ctl <= '1;
        rst_b <= 1'b0;
        #1;
        check_reset();
        repeat (2) @(posedge clk_sys);
        #1;
        check_reset();
        @(posedge clk_sys);
        ctl <= '0;
        rst_b <= 1'b1;
        @(posedge clk_sys);
        #1;
        cmp_vec(32'({pins.addr_oe, pins.lanes_oe, pins.tdo_oe}), 32'h7);
    endtask : run_mid_reset

    // Main sequence.
    initial begin
        repeat (9) @(posedge clk_sys);
        #1;
        check_reset();
        @(posedge clk_sys);
        rst_b <= 1'b1;
        run_lanes();
        run_mux();
        run_hold_busy();
        run_hold();
        run_reset_pin();
        run_mid_reset();
        repeat (2) @(posedge clk_sys);
        print_verdict();
    end

    // The whole run needs well under a thousand cycles; this cuts a hang short.
    initial begin
        #200000;
        failures++;
        print_verdict();
    end
endmodule : bpl_pin_lanes_tb
